// File: hw/dcf_pkg.sv
package dcf_pkg;

    // Data path and storage geometry.
    localparam int DATA_W = 9;
    localparam int ADDR_W = 8;
    localparam int CNT_W  = 9;
    localparam logic [CNT_W-1:0] DEPTH = 9'h100;

    // Offset register file geometry.
    localparam int OFF_W  = 8;
    localparam int OFF_N  = 4;

    // Rotating load and read positions of the offset registers.
    localparam logic [1:0] OFF_EMPTY_LO = 2'h0;
    localparam logic [1:0] OFF_EMPTY_HI = 2'h1;
    localparam logic [1:0] OFF_FULL_LO  = 2'h2;
    localparam logic [1:0] OFF_FULL_HI  = 2'h3;
    localparam logic [1:0] OFF_POS_RST  = 2'h0;

    // Four offset bytes, index 0 is the empty offset low byte.
    typedef logic [OFF_N-1:0][OFF_W-1:0] dcf_off_t;

    // Both offsets default to seven words.
    localparam dcf_off_t OFF_DEFAULT = {8'h00, 8'h07, 8'h00, 8'h07};

    // Values held by the data path and flags after reset.
    localparam logic [DATA_W-1:0] RDATA_RST = 9'h000;
    localparam logic [ADDR_W-1:0] PTR_RST   = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_RST   = 9'h000;
    localparam logic FULL_N_RST    = 1'b1;
    localparam logic AFULL_N_RST   = 1'b1;
    localparam logic EMPTY_N_RST   = 1'b0;
    localparam logic AEMPTY_N_RST  = 1'b0;
    localparam logic OE_RST        = 1'b0;

    // Reset-to-flag time and its count of system clock cycles.
    localparam int CLK_PERIOD_NS = 10;
    localparam int RSF_NS        = 10;
    localparam int RSF_CYC_RAW   = RSF_NS / CLK_PERIOD_NS;
    localparam int RSF_CYC       = (RSF_CYC_RAW < 1) ? 1 : RSF_CYC_RAW;

    // Configuration caught while the device reset pin is low.
    typedef enum logic {
        DCF_MODE_PROG = 1'b0,
        DCF_MODE_TWO  = 1'b1
    } dcf_mode_t;

    // Every pin input of the device, carried through the synchroniser.
    typedef struct packed {
        logic              mrst_n;
        logic              wclk;
        logic              wen_a_n;
        logic              wen_b_ld;
        logic [DATA_W-1:0] wdata;
        logic              rclk;
        logic              ren_a_n;
        logic              ren_b_n;
        logic              oe_n;
    } dcf_pins_t;

    // Synchroniser contents after reset: device held in reset, idle.
    localparam dcf_pins_t PINS_RST = '{
        mrst_n:   1'b0,
        wclk:     1'b0,
        wen_a_n:  1'b1,
        wen_b_ld: 1'b0,
        wdata:    9'h000,
        rclk:     1'b0,
        ren_a_n:  1'b1,
        ren_b_n:  1'b1,
        oe_n:     1'b1
    };

endpackage

// File: hw/dcf_sync.sv
`timescale 1ns/10ps
module dcf_sync #(
    parameter int            W    = 1,
    parameter logic [W-1:0]  INIT = '0
) (
    // System clock and reset.
    input  logic          clk,
    input  logic          resetn,
    // Asynchronous inputs and their synchronised copy.
    input  logic [W-1:0]  d,
    output logic [W-1:0]  q
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;

    // Two flip-flops in a row; only the second stage is seen outside.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_r <= INIT;
            s2_r <= INIT;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end

    assign q = s2_r;

endmodule // dcf_sync

// File: hw/dcf_mem.sv
`timescale 1ns/10ps
module dcf_mem #(
    parameter int AW = 8,
    parameter int DW = 9
) (
    // System clock.
    input  logic          clk,
    // Write port.
    input  logic          wr_en,
    input  logic [AW-1:0] wr_addr,
    input  logic [DW-1:0] wr_data,
    // Read port, combinational.
    input  logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);

    logic [DW-1:0] mem_r [2**AW];

    // Storage array; it has no reset, the pointers decide what is valid.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    // The word under the read pointer is always on offer.
    assign rd_data = mem_r[rd_addr];

endmodule // dcf_mem

// File: hw/dcf_fifo.sv
// What this block does
// - Device reset puts the read and write pointers on the first location.
// - Reset drives full and almost-full high, empty and almost-empty low.
// - Reset clears the output register and restores default offsets.
// - Writes and full-side flags move only on write clock rising edges.
// - Write and read clocks may be unrelated or the same clock.
// - Flag mode stores a word per write edge while enable A is low and load is high.
// - Two-enable mode writes only with enable A low and enable B high.
// - The dual-purpose pin is latched during reset to choose the mode.
// - Full holds full low and ignores writes; a read lets it rise.
// - Full goes low after as many writes as the buffer depth.
// - A read edge with both read enables low loads the output register.
// - Either read enable high keeps the output register unchanged.
// - A zero fill level gives empty low on read clock; reads then ignored.
// - A write into an empty buffer raises empty on a later read edge.
// - Output drive low drives read data; high leaves the bus undriven.
// - Flag mode offers four byte-wide offset registers, writable and readable.
// - Load edges rotate empty low, empty high, full low, full high, wrap.
// - Leaving load mode keeps the position; the next load continues.
// - Load low plus both read enables reads offsets in the same rotation.
// - Almost-full goes low at depth minus the full offset, default seven.
// - Almost-empty low when fill is at most the empty offset, on read clock.
// - Almost-empty low from zero to n; almost-full low from depth minus m.
// - Empty and full offsets both default to seven after reset.
`timescale 1ns/10ps
module dcf_fifo
    import dcf_pkg::*;
(
    // System clock and reset.
    input  logic              clk,
    input  logic              resetn,
    // Device reset pin.
    input  logic              master_reset_n,
    // Write port pins.
    input  logic              write_clock,
    input  logic              write_enable_a_n,
    input  logic              write_enable_b_or_load,
    input  logic [DATA_W-1:0] write_data,
    // Read port pins.
    input  logic              read_clock,
    input  logic              read_enable_a_n,
    input  logic              read_enable_b_n,
    input  logic              output_drive_n,
    // Read data bus with its output enable.
    output logic [DATA_W-1:0] read_data,
    output logic              read_data_oe,
    // Status flags, all active low.
    output logic              full_n,
    output logic              almost_full_n,
    output logic              empty_n,
    output logic              almost_empty_n
);

    dcf_pins_t         pins_raw;
    dcf_pins_t         pins;
    logic              wclk_d_r;
    logic              rclk_d_r;
    logic              wclk_rise;
    logic              rclk_rise;
    logic              dev_rst;
    logic              wr_ok;
    logic              ld_wr;
    logic              rd_both;
    logic              off_rd;
    logic              rd_ok;
    logic [DATA_W-1:0] mem_rd_data;
    logic [15:0]       empty_off;
    logic [15:0]       full_off;
    logic [16:0]       fill_plus_m;
    logic [ADDR_W-1:0] wr_ptr_r;
    logic [ADDR_W-1:0] wr_ptr_nxt;
    logic [ADDR_W-1:0] rd_ptr_r;
    logic [ADDR_W-1:0] rd_ptr_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic              oe_r;
    logic              oe_nxt;
    logic              full_n_r;
    logic              full_n_nxt;
    logic              afull_n_r;
    logic              afull_n_nxt;
    logic              empty_n_r;
    logic              empty_n_nxt;
    logic              aempty_n_r;
    logic              aempty_n_nxt;
    dcf_off_t          off_r;
    dcf_off_t          off_nxt;
    logic [1:0]        ld_pos_r;
    logic [1:0]        ld_pos_nxt;
    dcf_mode_t         mode_r;
    dcf_mode_t         mode_nxt;

    // Gather every pin into one word so they share the same delay.
    assign pins_raw = '{
        mrst_n:   master_reset_n,
        wclk:     write_clock,
        wen_a_n:  write_enable_a_n,
        wen_b_ld: write_enable_b_or_load,
        wdata:    write_data,
        rclk:     read_clock,
        ren_a_n:  read_enable_a_n,
        ren_b_n:  read_enable_b_n,
        oe_n:     output_drive_n
    };

    // Both pin clocks and their qualifiers cross into clk together.
    dcf_sync #(
        .W    ($bits(dcf_pins_t)),
        .INIT (PINS_RST)
    ) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      (pins_raw),
        .q      (pins)
    );

    // Storage array, written at the write pointer, read at the read one.
    dcf_mem #(
        .AW (ADDR_W),
        .DW (DATA_W)
    ) u_mem (
        .clk     (clk),
        .wr_en   (wr_ok),
        .wr_addr (wr_ptr_r),
        .wr_data (pins.wdata),
        .rd_addr (rd_ptr_r),
        .rd_data (mem_rd_data)
    );

    // Pin clock edges become one-cycle events, shared clocks alike.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wclk_d_r <= 1'b0;
            rclk_d_r <= 1'b0;
        end else begin
            wclk_d_r <= pins.wclk;
            rclk_d_r <= pins.rclk;
        end
    end
    assign wclk_rise = pins.wclk && !wclk_d_r;
    assign rclk_rise = pins.rclk && !rclk_d_r;
    assign dev_rst   = !pins.mrst_n;

    // Offsets in use; in two-enable mode they stay at the defaults.
    assign empty_off   = {off_r[OFF_EMPTY_HI], off_r[OFF_EMPTY_LO]};
    assign full_off    = {off_r[OFF_FULL_HI], off_r[OFF_FULL_LO]};
    assign fill_plus_m = {8'h00, cnt_nxt} + {1'b0, full_off};

    // Decode the accepted operations of this cycle.
    always_comb begin
        // A write needs enable A low and pin B high; full refuses it.
        wr_ok   = wclk_rise && !dev_rst && !pins.wen_a_n
                  && pins.wen_b_ld && full_n_r;
        // Offset load only exists in the programmable-flag mode.
        ld_wr   = wclk_rise && !dev_rst && (mode_r == DCF_MODE_PROG)
                  && !pins.wen_a_n && !pins.wen_b_ld;
        rd_both = rclk_rise && !dev_rst
                  && !pins.ren_a_n && !pins.ren_b_n;
        off_rd  = rd_both && (mode_r == DCF_MODE_PROG)
                  && !pins.wen_b_ld;
        // Reads of the array are ignored while the empty flag is low.
        rd_ok   = rd_both && !off_rd && empty_n_r;
    end

    // Next values of pointers, fill level, output register and flags.
    always_comb begin
        wr_ptr_nxt   = wr_ptr_r;
        rd_ptr_nxt   = rd_ptr_r;
        cnt_nxt      = cnt_r;
        rdata_nxt    = rdata_r;
        full_n_nxt   = full_n_r;
        afull_n_nxt  = afull_n_r;
        empty_n_nxt  = empty_n_r;
        aempty_n_nxt = aempty_n_r;
        oe_nxt       = !pins.oe_n;
        if (dev_rst) begin
            wr_ptr_nxt   = PTR_RST;
            rd_ptr_nxt   = PTR_RST;
            cnt_nxt      = CNT_RST;
            rdata_nxt    = RDATA_RST;
            full_n_nxt   = FULL_N_RST;
            afull_n_nxt  = AFULL_N_RST;
            empty_n_nxt  = EMPTY_N_RST;
            aempty_n_nxt = AEMPTY_N_RST;
        end else begin
            // An eight-bit pointer over 256 words wraps by itself.
            if (wr_ok) begin
                wr_ptr_nxt = wr_ptr_r + 8'h01;
                cnt_nxt    = cnt_nxt + 9'h001;
            end
            if (rd_ok) begin
                rd_ptr_nxt = rd_ptr_r + 8'h01;
                cnt_nxt    = cnt_nxt - 9'h001;
                rdata_nxt  = mem_rd_data;
            end else if (off_rd) begin
                rdata_nxt  = {1'b0, off_r[ld_pos_r]};
            end
            // Full-side flags follow the write clock only.
            if (wclk_rise) begin
                full_n_nxt  = (cnt_nxt != DEPTH);
                afull_n_nxt = (fill_plus_m < {8'h00, DEPTH});
            end
            // Empty-side flags move on read edges; a write shows later.
            if (rclk_rise) begin
                empty_n_nxt  = (cnt_nxt != CNT_RST);
                aempty_n_nxt = ({7'h00, cnt_nxt} > empty_off);
            end
        end
    end

    // Register the data path and flags.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wr_ptr_r   <= PTR_RST;
            rd_ptr_r   <= PTR_RST;
            cnt_r      <= CNT_RST;
            rdata_r    <= RDATA_RST;
            oe_r       <= OE_RST;
            full_n_r   <= FULL_N_RST;
            afull_n_r  <= AFULL_N_RST;
            empty_n_r  <= EMPTY_N_RST;
            aempty_n_r <= AEMPTY_N_RST;
        end else begin
            wr_ptr_r   <= wr_ptr_nxt;
            rd_ptr_r   <= rd_ptr_nxt;
            cnt_r      <= cnt_nxt;
            rdata_r    <= rdata_nxt;
            oe_r       <= oe_nxt;
            full_n_r   <= full_n_nxt;
            afull_n_r  <= afull_n_nxt;
            empty_n_r  <= empty_n_nxt;
            aempty_n_r <= aempty_n_nxt;
        end
    end

    // Next values of the offset bytes, their position and the mode.
    always_comb begin
        off_nxt    = off_r;
        ld_pos_nxt = ld_pos_r;
        mode_nxt   = mode_r;
        if (dev_rst) begin
            off_nxt    = OFF_DEFAULT;
            ld_pos_nxt = OFF_POS_RST;
            mode_nxt   = dcf_mode_t'(pins.wen_b_ld);
        end else if (ld_wr) begin
            // Load and read share one position, so a partial load resumes.
            off_nxt[ld_pos_r] = pins.wdata[OFF_W-1:0];
            ld_pos_nxt        = ld_pos_r + 2'h1;
        end else if (off_rd) begin
            ld_pos_nxt        = ld_pos_r + 2'h1;
        end
    end

    // Register the offset bytes, position and mode.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            off_r    <= OFF_DEFAULT;
            ld_pos_r <= OFF_POS_RST;
            mode_r   <= DCF_MODE_PROG;
        end else begin
            off_r    <= off_nxt;
            ld_pos_r <= ld_pos_nxt;
            mode_r   <= mode_nxt;
        end
    end

    // Every output comes straight from a flip-flop.
    assign read_data      = rdata_r;
    assign read_data_oe   = oe_r;
    assign full_n         = full_n_r;
    assign almost_full_n  = afull_n_r;
    assign empty_n        = empty_n_r;
    assign almost_empty_n = aempty_n_r;

    // Checks on the behaviour above, all in the clk domain.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Device reset returns both pointers to the first location.
    property p_ptr_reset;
        dev_rst |=> (wr_ptr_r == PTR_RST) && (rd_ptr_r == PTR_RST);
    endproperty
    a_ptr_reset: assert property (p_ptr_reset)
        else $error("pointers not cleared by device reset");

    // Flags reach their reset levels within one cycle of reset.
    property p_flag_reset;
        dev_rst |-> ##1 (full_n_r && afull_n_r && !empty_n_r && !aempty_n_r);
    endproperty
    a_flag_reset: assert property (p_flag_reset)
        else $error("flags wrong after device reset");

    // Reset clears the output register and restores default offsets.
    property p_out_reset;
        dev_rst |=> (rdata_r == RDATA_RST) && (off_r == OFF_DEFAULT);
    endproperty
    a_out_reset: assert property (p_out_reset)
        else $error("output register or offsets not reset");

    // Full-side flags change only on write clock edges.
    property p_full_sync;
        (!wclk_rise && !dev_rst) |=> $stable(full_n_r) && $stable(afull_n_r);
    endproperty
    a_full_sync: assert property (p_full_sync)
        else $error("full side flag moved without write edge");

    // A full buffer never advances the write pointer.
    property p_full_ignore;
        (!full_n_r && !dev_rst) |=> $stable(wr_ptr_r);
    endproperty
    a_full_ignore: assert property (p_full_ignore)
        else $error("write accepted while full");

    // After a write edge the full flag matches the fill level.
    property p_full_level;
        (wclk_rise && !dev_rst) |=> (full_n_r == (cnt_r != DEPTH));
    endproperty
    a_full_level: assert property (p_full_level)
        else $error("full flag disagrees with fill level");

    // The mode only changes while the device reset pin is low.
    property p_mode_hold;
        !dev_rst |=> (mode_r == $past(mode_r)) || $past(dev_rst);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("mode changed outside device reset");

    // Without an accepted read the output register holds.
    property p_rd_hold;
        (!rd_ok && !off_rd && !dev_rst) |=> $stable(rdata_r);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("output register changed without a read");

    // An empty buffer never advances the read pointer.
    property p_empty_ignore;
        (!empty_n_r && !dev_rst) |=> $stable(rd_ptr_r);
    endproperty
    a_empty_ignore: assert property (p_empty_ignore)
        else $error("read accepted while empty");

    // The bus enable follows the synchronised output drive pin one cycle later.
    property p_oe;
        1'b1 |=> (oe_r == !$past(pins.oe_n));
    endproperty
    a_oe: assert property (p_oe)
        else $error("read data enable does not follow pin");

    // Each offset load moves the position one step around four.
    property p_ld_rotate;
        (ld_wr || off_rd) |=> (ld_pos_r == 2'($past(ld_pos_r) + 2'h1));
    endproperty
    a_ld_rotate: assert property (p_ld_rotate)
        else $error("offset position did not rotate");

    // After a read edge almost-empty matches fill against the offset.
    property p_aempty;
        (rclk_rise && !dev_rst) |=> aempty_n_r == ({7'h00, cnt_r} > empty_off);
    endproperty
    a_aempty: assert property (p_aempty)
        else $error("almost empty flag disagrees with fill");

endmodule // dcf_fifo

// File: dv/dcf_partner.sv
`timescale 1ns/10ps
module dcf_partner
    import dcf_pkg::*;
(
    // System clock.
    input  logic              clk,
    // Writer logic pins.
    output logic              master_reset_n,
    output logic              write_clock,
    output logic              write_enable_a_n,
    output logic              write_enable_b_or_load,
    output logic [DATA_W-1:0] write_data,
    // Reader logic pins.
    output logic              read_clock,
    output logic              read_enable_a_n,
    output logic              read_enable_b_n
);
    // Pins idle at time zero with the device held in reset.
    initial begin
        master_reset_n = 1'b0;
        write_clock = 1'b0;
        read_clock = 1'b0;
        write_data = 9'h000;
        write_enable_a_n = 1'b1;
        write_enable_b_or_load = 1'b0;
        read_enable_a_n = 1'b1;
        read_enable_b_n = 1'b1;
    end

    // Returns write enable A and both read enables to inactive high, and sets the B/load pin high.
    task automatic idle();
        write_enable_a_n = 1'b1;
        write_enable_b_or_load = 1'b1;
        read_enable_a_n = 1'b1;
        read_enable_b_n = 1'b1;
    endtask

    // Resets the device with the mode pin held at the given level.
    task automatic dev_reset(input logic mode);
        @(posedge clk);
        #1 master_reset_n = 1'b0;
        write_enable_b_or_load = mode;
        repeat (6) @(posedge clk);
        #1 master_reset_n = 1'b1;
        repeat (6) @(posedge clk);
        #1 write_enable_b_or_load = 1'b1;
    endtask

    // One pin clock pulse; only one side is clocked at a time.
    task automatic pulse(input logic is_rd);
        repeat (3) @(posedge clk);
        #1 {read_clock, write_clock} = {is_rd, !is_rd};
        repeat (3) @(posedge clk);
        #1 {read_clock, write_clock} = 2'b00;
        idle();
        repeat (3) @(posedge clk);
        #2;
    endtask

    // One write clock edge with the given enables and data.
    task automatic wr(input logic a_n, input logic b,
                      input logic [DATA_W-1:0] d);
        @(posedge clk);
        #1 write_enable_a_n = a_n;
        write_enable_b_or_load = b;
        write_data = d;
        pulse(1'b0);
    endtask

    // One read clock edge with the load pin and both read enables.
    task automatic rd(input logic ld, input logic a_n, input logic b_n);
        @(posedge clk);
        #1 write_enable_b_or_load = ld;
        read_enable_a_n = a_n;
        read_enable_b_n = b_n;
        pulse(1'b1);
    endtask
endmodule // dcf_partner

// File: dv/dual_clock_fifo_prog_flags_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
    checks++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("wrong value %s exp %h got %h", nm, e, g); \
    end \
end
module dual_clock_fifo_prog_flags_tb
    import dcf_pkg::*;
;
    logic              clk;
    logic              resetn;
    logic              output_drive_n;
    logic              master_reset_n;
    logic              write_clock;
    logic              write_enable_a_n;
    logic              write_enable_b_or_load;
    logic [DATA_W-1:0] write_data;
    logic              read_clock;
    logic              read_enable_a_n;
    logic              read_enable_b_n;
    logic [DATA_W-1:0] read_data;
    logic              read_data_oe;
    logic              full_n;
    logic              almost_full_n;
    logic              empty_n;
    logic              almost_empty_n;
    int                fail_count;
    int                checks;
    int                n;
    int                m;
    dcf_off_t          offs;

    // Device under test and the writer and reader model.
    dcf_fifo dut (.clk, .resetn, .master_reset_n, .write_clock,
        .write_enable_a_n, .write_enable_b_or_load, .write_data,
        .read_clock, .read_enable_a_n, .read_enable_b_n, .output_drive_n,
        .read_data, .read_data_oe, .full_n, .almost_full_n, .empty_n,
        .almost_empty_n);
    dcf_partner u_pt (.clk, .master_reset_n, .write_clock,
        .write_enable_a_n, .write_enable_b_or_load, .write_data,
        .read_clock, .read_enable_a_n, .read_enable_b_n);

    // System clock, 10 ns period.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Reads the four offset bytes in rotation and compares them.
    task automatic offs_rd(input dcf_off_t e);
        for (int i = 0; i < OFF_N; i++) begin
            u_pt.rd(1'b0, 1'b0, 1'b0);
            `CHK("offset", {1'b0, e[i]}, read_data)
        end
    endtask

    // Fills to full with random gaps, then drains with random stalls.
    task automatic fill_drain(input int ne, input int me);
        logic [DATA_W-1:0] q[$];
        logic [DATA_W-1:0] d;
        logic              skip;
        int                lvl;
        lvl = 0;
        while (lvl < 256) begin
            d = DATA_W'($urandom);
            skip = ($urandom % 4) == 0;
            u_pt.wr(skip, 1'b1, d);
            if (!skip) begin
                q.push_back(d);
                lvl++;
            end
            `CHK("full_n", 1'(lvl < 256), full_n)
            `CHK("almost_full_n", 1'(lvl + me < 256), almost_full_n)
        end
        u_pt.wr(1'b0, 1'b1, 9'h1FF);
        `CHK("full_n", 1'b0, full_n)
        u_pt.rd(1'b1, 1'b1, 1'b1);
        `CHK("empty_n", 1'b1, empty_n)
        while (lvl > 0) begin
            skip = (lvl < 256) && (($urandom % 4) == 0);
            u_pt.rd(1'b1, 1'b0, skip);
            if (!skip) begin
                d = q.pop_front();
                lvl--;
            end
            `CHK("read_data", d, read_data)
            `CHK("empty_n", 1'(lvl > 0), empty_n)
            `CHK("almost_empty_n", 1'(lvl > ne), almost_empty_n)
        end
        u_pt.rd(1'b1, 1'b0, 1'b0);
        `CHK("read_data", d, read_data)
        u_pt.wr(1'b0, 1'b1, 9'h0AA);
        `CHK("full_n", 1'b1, full_n)
    endtask

    // Main sequence.
    initial begin
        fail_count = 0;
        checks = 0;
        resetn = 1'b0;
        output_drive_n = 1'b0;
        void'($urandom(32'hA880));
        repeat (5) @(posedge clk);
        #1 resetn = 1'b1;
        u_pt.dev_reset(DCF_MODE_PROG);
        `CHK("full_n", 1'b1, full_n)
        `CHK("almost_full_n", 1'b1, almost_full_n)
        `CHK("empty_n", 1'b0, empty_n)
        `CHK("almost_empty_n", 1'b0, almost_empty_n)
        `CHK("read_data", 9'h000, read_data)
        u_pt.rd(1'b1, 1'b0, 1'b0);
        `CHK("read_data", 9'h000, read_data)
        @(posedge clk);
        #1 output_drive_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 `CHK("read_data_oe", 1'b0, read_data_oe)
        output_drive_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 `CHK("read_data_oe", 1'b1, read_data_oe)
        offs_rd({8'h00, 8'h07, 8'h00, 8'h07});
        n = 1 + $urandom % 20;
        m = 1 + $urandom % 20;
        offs = {8'h00, 8'(m), 8'h00, 8'(n)};
        for (int i = 0; i < OFF_N; i++) begin
            if (i == 2) begin
                u_pt.wr(1'b1, 1'b1, 9'h000);
            end
            u_pt.wr(1'b0, 1'b0, {1'b0, offs[i]});
        end
        offs_rd(offs);
        fill_drain(n, m);
        u_pt.dev_reset(DCF_MODE_TWO);
        u_pt.wr(1'b0, 1'b0, 9'h055);
        fill_drain(7, 7);
        results();
    end

    // Watchdog against a hang.
    initial begin
        #400_000;
        fail_count++;
        results();
    end
endmodule // dual_clock_fifo_prog_flags_tb
